// file: src/lapb_link_ctrl.sv
// Bit-oriented LAPB link controller: registers, DMA, framer and deframer.
`timescale 1ns/1ps
module lapb_link_ctrl (
	input  wire logic        clock,
	input  wire logic        rstn,
	input  wire logic        link_clock,
	input  wire logic        chip_select_n,
	input  wire logic        read_strobe_n,
	input  wire logic        write_strobe_n,
	input  wire logic [3:0]  reg_select,
	input  wire logic [7:0]  data_in,
	output logic      [7:0]  data_out,
	output logic             data_oe,
	input  wire logic        dma_grant_n,
	output logic             dma_out_request_n,
	output logic             dma_in_request_n,
	output logic      [15:0] dma_addr_out,
	output logic             dma_addr_oe,
	output logic             irq_n,
	output logic             tx_serial,
	input  wire logic        rx_serial
);
	import lapb_pkg::*;

	function automatic logic [15:0] crc_step(input logic [15:0] c,
	                                         input logic b);
		crc_step = (c[0] ^ b) ? ((c >> 1) ^ CRC_POLY_REV) : (c >> 1);
	endfunction

	// Host side register file.
	logic [7:0]  ctl0_q, ctl1_q, rtim_q, rcnt_q, tth_q, ttl_q, cbs_q;
	logic [7:0]  cmd_q, rsp_q, rcf_q, err_q;
	logic [2:0]  ev_q;
	logic [7:0]  rd_mux;
	logic [15:0] dma_ptr_q;
	wire         host_wr = !chip_select_n && !write_strobe_n;
	wire         host_rd = !chip_select_n && !read_strobe_n;
	logic        host_rd_q;
	wire         ev_read = host_rd && !host_rd_q &&
	                       reg_select == REG_EVENT_STATUS;
	wire         addr_drive = ctl1_q[CR1_ADDR_DRIVE_BIT];

	// Crossing from link domain: toggles for events, words held stable.
	logic        rxb_tgl_l, rxe_tgl_l, txr_tgl_l;
	logic [2:0]  rxb_s, rxe_s, txr_s;
	lapb_rx_byte_s rxb_word_l;
	logic        rxe_bad_l;
	logic [7:0]  rxe_ctl_l;
	wire rxb_evt = rxb_s[2] ^ rxb_s[1];
	wire rxe_evt = rxe_s[2] ^ rxe_s[1];
	wire txr_evt = txr_s[2] ^ txr_s[1];
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rxb_s <= 3'h0;
			rxe_s <= 3'h0;
			txr_s <= 3'h0;
		end else begin
			rxb_s <= {rxb_s[1:0], rxb_tgl_l};
			rxe_s <= {rxe_s[1:0], rxe_tgl_l};
			txr_s <= {txr_s[1:0], txr_tgl_l};
		end
	end

	// Three-deep receive FIFO; a frame's bytes wait until its CRC is known.
	logic [7:0] fifo_q [RX_FIFO_DEPTH];
	logic [1:0] fcnt_q, pend_q;
	wire        fifo_full = fcnt_q == 2'(RX_FIFO_DEPTH);
	wire        dma_in_take = !dma_grant_n && !dma_in_request_n;
	wire        push = rxb_evt && !fifo_full && ctl0_q[CR0_RX_READY_BIT];
	wire        frame_ok = rxe_evt && !rxe_bad_l;
	wire        frame_bad = rxe_evt && rxe_bad_l;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			fcnt_q <= 2'h0;
			pend_q <= 2'h0;
			for (int i = 0; i < RX_FIFO_DEPTH; i++) fifo_q[i] <= 8'h00;
		end else begin
			if (frame_bad) begin
				fcnt_q <= fcnt_q - pend_q;
				pend_q <= 2'h0;
			end else begin
				if (frame_ok) pend_q <= 2'h0;
				else if (push) pend_q <= pend_q + 2'h1;
				if (dma_in_take && !push) begin
					fcnt_q <= fcnt_q - 2'h1;
					fifo_q[0] <= fifo_q[1];
					fifo_q[1] <= fifo_q[2];
				end else if (push && !dma_in_take) begin
					fcnt_q <= fcnt_q + 2'h1;
					fifo_q[fcnt_q] <= rxb_word_l.data;
				end else if (push) begin
					fifo_q[0] <= fifo_q[1];
					fifo_q[1] <= fifo_q[2];
					fifo_q[fcnt_q - 2'h1] <= rxb_word_l.data;
				end
			end
		end
	end

	// Only committed bytes may leave; pending ones belong to an open frame.
	wire ready_in = (fcnt_q > pend_q) && !ctl0_q[CR0_MANUAL_DISC_BIT];
	logic txh_full_q;
	assign dma_in_request_n = !ready_in;
	wire dma_out_take = !dma_grant_n && !dma_out_request_n;
	assign dma_out_request_n = txh_full_q || ctl0_q[CR0_MANUAL_DISC_BIT] ||
	                           !ctl1_q[CR1_SEND_BIT];

	// Transmit holding register, loaded by outbound DMA.
	logic [7:0] txh_q;
	logic       txh_tgl_q;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			txh_q      <= 8'h00;
			txh_full_q <= 1'b0;
			txh_tgl_q  <= 1'b0;
		end else if (dma_out_take) begin
			txh_q      <= data_in;
			txh_full_q <= 1'b1;
			txh_tgl_q  <= ~txh_tgl_q;
		end else if (txr_evt) begin
			txh_full_q <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ctl0_q <= CR0_RESET;
			ctl1_q <= REG_RESET;
			rtim_q <= REG_RESET;
			rcnt_q <= REG_RESET;
			tth_q  <= REG_RESET;
			ttl_q  <= REG_RESET;
			cbs_q  <= REG_RESET;
			cmd_q  <= REG_RESET;
			rsp_q  <= REG_RESET;
		end else if (host_wr) begin
			unique case (reg_select)
				REG_CONTROL_ZERO:   ctl0_q <= data_in;
				REG_CONTROL_ONE:    ctl1_q <= data_in;
				REG_RETRY_TIMER:    rtim_q <= data_in;
				REG_RETRY_COUNT:    rcnt_q <= data_in;
				REG_TX_TABLE_HI:    tth_q  <= data_in;
				REG_TX_TABLE_LO:    ttl_q  <= data_in;
				REG_CHAIN_BUF_SIZE: cbs_q  <= data_in;
				REG_TX_CMD_ADDR:    cmd_q  <= data_in;
				REG_TX_RSP_ADDR:    rsp_q  <= data_in;
				default:            ;
			endcase
		end
	end

	// Event bits: a set in the same cycle as the clearing read wins.
	wire [2:0] ev_set = {frame_ok && rxe_ctl_l[0] == 1'b0,
	                     txr_evt && !txh_full_q,
	                     frame_bad || (rxb_evt && fifo_full)};
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ev_q      <= 3'h0;
			err_q     <= 8'h00;
			rcf_q     <= 8'h00;
			host_rd_q <= 1'b0;
			dma_ptr_q <= 16'h0000;
		end else begin
			host_rd_q <= host_rd;
			ev_q      <= (ev_read ? 3'h0 : ev_q) | ev_set;
			if (frame_bad) err_q[ER_CRC_BIT] <= 1'b1;
			if (rxb_evt && fifo_full) err_q[ER_OVERRUN_BIT] <= 1'b1;
			if (frame_ok) rcf_q <= rxe_ctl_l;
			if (dma_in_take || dma_out_take)
				dma_ptr_q <= dma_ptr_q + 16'h0001;
			else if (host_wr && reg_select == REG_TX_TABLE_LO)
				dma_ptr_q <= {tth_q, data_in};
		end
	end
	assign irq_n = !(|ev_q);

	wire [7:0] ev_byte = {ev_q, 5'h00};
	always_comb begin
		unique case (reg_select)
			REG_CONTROL_ZERO:   rd_mux = ctl0_q;
			REG_CONTROL_ONE:    rd_mux = ctl1_q;
			REG_SEQ_STATUS:     rd_mux = 8'h00;
			REG_EVENT_STATUS:   rd_mux = ev_byte;
			REG_LINK_STATUS:    rd_mux = {2'h0, fcnt_q == 2'h0, 5'h00};
			REG_ERROR_STATUS:   rd_mux = err_q;
			REG_CHAIN_MONITOR:  rd_mux = {6'h00, fcnt_q};
			REG_RX_CTRL_FIELD:  rd_mux = rcf_q;
			REG_RETRY_TIMER:    rd_mux = rtim_q;
			REG_RETRY_COUNT:    rd_mux = rcnt_q;
			REG_TX_TABLE_HI:    rd_mux = tth_q;
			REG_TX_TABLE_LO:    rd_mux = ttl_q;
			REG_CHAIN_BUF_SIZE: rd_mux = cbs_q;
			REG_TX_CMD_ADDR:    rd_mux = cmd_q;
			REG_TX_RSP_ADDR:    rd_mux = rsp_q;
			default:            rd_mux = 8'h00;
		endcase
	end
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) data_out <= 8'h00;
		else if (dma_in_take) data_out <= fifo_q[0];
		else data_out <= rd_mux;
	end
	assign data_oe = host_rd || dma_in_take;
	assign dma_addr_out = dma_ptr_q;
	assign dma_addr_oe = addr_drive || !dma_grant_n;

	// Link domain: transmitter.
	logic [1:0]  rxd_s;
	logic [2:0]  th_s;
	logic [7:0]  tsh_q;
	logic [3:0]  tbit_q;
	logic [2:0]  tones_q;
	logic [15:0] tcrc_q;
	typedef enum {TX_FLAG, TX_DATA, TX_FCS} lapb_tx_e;
	lapb_tx_e    tst_q;
	logic        tfl_tgl_q;
	// A waiting byte is a level: the synced toggle differs from the taken
	// one, so a byte that lands mid-byte is still picked up at the boundary.
	wire         th_evt = th_s[2] ^ txr_tgl_l;
	// The first flag bit is still stuffed after an FCS ending in five ones.
	wire         stuff = tones_q == 3'(ONES_LIMIT) &&
	                     (tst_q != TX_FLAG || tbit_q == 4'h0);
	wire         tbit = stuff ? 1'b0 : tsh_q[0];
	wire [15:0]  tcrc_nx = crc_step(tcrc_q, tsh_q[0]);
	always_ff @(posedge link_clock or negedge rstn) begin
		if (!rstn) begin
			th_s      <= 3'h0;
			tsh_q     <= FLAG_PATTERN;
			tbit_q    <= 4'h0;
			tones_q   <= 3'h0;
			tcrc_q    <= CRC_INIT;
			tst_q     <= TX_FLAG;
			txr_tgl_l <= 1'b0;
			tfl_tgl_q <= 1'b0;
			tx_serial <= 1'b1;
		end else begin
			th_s      <= {th_s[1:0], txh_tgl_q};
			tx_serial <= tbit;
			if (stuff) tones_q <= 3'h0;
			else begin
				tones_q <= tsh_q[0] ? tones_q + 3'h1 : 3'h0;
				if (tst_q == TX_DATA)
					tcrc_q <= crc_step(tcrc_q, tsh_q[0]);
				tsh_q  <= {1'b0, tsh_q[7:1]};
				tbit_q <= tbit_q + 4'h1;
				if (tbit_q == 4'h7 && tst_q != TX_FCS) begin
					tbit_q <= 4'h0;
					if (tst_q == TX_FLAG) tcrc_q <= CRC_INIT;
					if (th_evt) begin
						tsh_q     <= txh_q;
						tst_q     <= TX_DATA;
						txr_tgl_l <= ~txr_tgl_l;
					end else if (tst_q == TX_DATA) begin
						tsh_q <= ~tcrc_nx[7:0];
						tcrc_q <= ~tcrc_nx;
						tst_q <= TX_FCS;
					end else tsh_q <= FLAG_PATTERN;
				end else if (tbit_q == 4'h7) begin
					tsh_q <= tcrc_q[15:8];
				end else if (tbit_q == 4'hf) begin
					tbit_q <= 4'h0;
					tsh_q  <= FLAG_PATTERN;
					tst_q  <= TX_FLAG;
				end
			end
		end
	end

	// Link domain: receiver with 24-bit shifter holding back the FCS.
	logic [23:0] rsh_q;
	logic [2:0]  rones_q;
	logic [7:0]  rwin_q;
	logic [2:0]  rbit_q;
	logic [15:0] rcrc_q;
	logic [4:0]  rcnt_l;
	logic [7:0]  rctl_l;
	logic        rin_q;
	wire         rb = rxd_s[1];
	wire [7:0]   rwin_n = {rb, rwin_q[7:1]};
	wire         rdel = rones_q == 3'(ONES_LIMIT) && !rb;
	always_ff @(posedge link_clock or negedge rstn) begin
		if (!rstn) begin
			rxd_s      <= 2'h0;
			rsh_q      <= 24'h00_0000;
			rones_q    <= 3'h0;
			rwin_q     <= 8'h00;
			rbit_q     <= 3'h0;
			rcrc_q     <= CRC_INIT;
			rcnt_l     <= 5'h00;
			rctl_l     <= 8'h00;
			rin_q      <= 1'b0;
			rxb_tgl_l  <= 1'b0;
			rxe_tgl_l  <= 1'b0;
			rxb_word_l <= '0;
			rxe_bad_l  <= 1'b0;
			rxe_ctl_l  <= 8'h00;
		end else begin
			rxd_s  <= {rxd_s[0], rx_serial};
			rwin_q <= rwin_n;
			rones_q <= rb ? (rones_q == 3'h7 ? 3'h7 : rones_q + 3'h1) : 3'h0;
			if (rwin_n == FLAG_PATTERN) begin
				if (rin_q && rcnt_l >= 5'h3) begin
					rxe_bad_l <= rcrc_q != CRC_GOOD_RESI;
					rxe_ctl_l <= rctl_l;
					rxe_tgl_l <= ~rxe_tgl_l;
				end
				rin_q  <= 1'b1;
				rbit_q <= 3'h0;
				rcnt_l <= 5'h00;
				rcrc_q <= CRC_INIT;
			end else if (rin_q && !rdel) begin
				// The CRC lags seven bits so the closing flag never enters it.
				if (rcnt_l != 5'h00 || rbit_q == 3'h7)
					rcrc_q <= crc_step(rcrc_q, rsh_q[17]);
				rsh_q  <= {rb, rsh_q[23:1]};
				rbit_q <= rbit_q + 3'h1;
				if (rbit_q == 3'h7) begin
					if (rcnt_l != 5'h1f) rcnt_l <= rcnt_l + 5'h01;
					if (rcnt_l == 5'h01) rctl_l <= {rb, rsh_q[23:17]};
					// Oldest byte leaves only once two newer ones follow;
					// only information bytes of I-frames reach the host.
					if (rcnt_l >= 5'h4 && !rctl_l[0]) begin
						rxb_word_l <= '{data: rsh_q[8:1], last: 1'b0};
						rxb_tgl_l  <= ~rxb_tgl_l;
					end
				end
			end
		end
	end
	chk_addr_drive_high: assert property (@(posedge clock) disable iff (!rstn)
		addr_drive |-> dma_addr_oe)
		else $error("address not driven");
	chk_addr_float_grant: assert property (@(posedge clock) disable iff (!rstn)
		(!addr_drive && dma_grant_n) |-> !dma_addr_oe)
		else $error("address driven while released");
	chk_irq_on_event: assert property (@(posedge clock) disable iff (!rstn)
		(|ev_set) |=> !irq_n)
		else $error("event did not raise interrupt");
	chk_irq_read_clear: assert property (@(posedge clock) disable iff (!rstn)
		(ev_read && ev_set == 3'h0) |=> irq_n)
		else $error("read did not clear interrupt");
	chk_ro_no_write: assert property (@(posedge clock) disable iff (!rstn)
		!host_wr |=> $stable(ctl0_q) && $stable(cmd_q))
		else $error("register changed without write");
	chk_fifo_bound: assert property (@(posedge clock) disable iff (!rstn)
		fcnt_q <= 2'(RX_FIFO_DEPTH))
		else $error("fifo overflow");
	chk_bad_drop: assert property (@(posedge clock) disable iff (!rstn)
		frame_bad |=> fcnt_q == $past(fcnt_q) - $past(pend_q))
		else $error("bad frame bytes kept");
	chk_stuff_zero: assert property (@(posedge link_clock) disable iff (!rstn)
		stuff |=> !tx_serial)
		else $error("no zero after five ones");
endmodule // lapb_link_ctrl

// file: src/lapb_pkg.sv
// Package with register map, field positions and link constants.
package lapb_pkg;
	localparam logic [3:0] REG_CONTROL_ZERO   = 4'h0;
	localparam logic [3:0] REG_CONTROL_ONE    = 4'h1;
	localparam logic [3:0] REG_SEQ_STATUS     = 4'h2;
	localparam logic [3:0] REG_EVENT_STATUS   = 4'h3;
	localparam logic [3:0] REG_LINK_STATUS    = 4'h4;
	localparam logic [3:0] REG_ERROR_STATUS   = 4'h5;
	localparam logic [3:0] REG_CHAIN_MONITOR  = 4'h6;
	localparam logic [3:0] REG_RX_CTRL_FIELD  = 4'h7;
	localparam logic [3:0] REG_RETRY_TIMER    = 4'h8;
	localparam logic [3:0] REG_RETRY_COUNT    = 4'h9;
	localparam logic [3:0] REG_TX_TABLE_HI    = 4'ha;
	localparam logic [3:0] REG_TX_TABLE_LO    = 4'hb;
	localparam logic [3:0] REG_CHAIN_BUF_SIZE = 4'hc;
	localparam logic [3:0] REG_UNUSED_SLOT    = 4'hd;
	localparam logic [3:0] REG_TX_CMD_ADDR    = 4'he;
	localparam logic [3:0] REG_TX_RSP_ADDR    = 4'hf;
	// Field positions.
	localparam int CR0_MANUAL_DISC_BIT = 0;
	localparam int CR0_RX_READY_BIT    = 1;
	localparam int CR1_ADDR_DRIVE_BIT  = 4;
	localparam int CR1_SEND_BIT        = 0;
	localparam int EV_PKT_RX_BIT       = 7;
	localparam int EV_TX_ACK_BIT       = 6;
	localparam int EV_ERROR_BIT        = 5;
	localparam int LS_RX_IDLE_BIT      = 5;
	localparam int ER_CRC_BIT          = 0;
	localparam int ER_OVERRUN_BIT      = 1;
	// Reset values.
	localparam logic [7:0] CR0_RESET   = 8'h01;
	localparam logic [7:0] REG_RESET   = 8'h00;
	// Framing constants.
	localparam logic [7:0]  FLAG_PATTERN  = 8'h7e;
	localparam logic [15:0] CRC_INIT      = 16'hffff;
	localparam logic [15:0] CRC_POLY_REV  = 16'h8408;
	localparam logic [15:0] CRC_GOOD_RESI = 16'hf0b8;
	localparam int          ONES_LIMIT    = 5;
	localparam int          RX_FIFO_DEPTH = 3;
	localparam logic [7:0]  I_FRAME_MASK  = 8'h01;
	typedef struct packed {
		logic [7:0] data;
		logic       last;
	} lapb_rx_byte_s;
endpackage

// file: sim/lapb_remote_station.sv
// Behavioural remote station on the serial link of the link controller.
`timescale 1ns/1ps
module lapb_remote_station (
	input  wire logic link_clock,
	input  wire logic tx_serial,
	output logic      rx_serial
);
	import lapb_pkg::*;
	logic       q_bits[$];
	logic       r_bits[$];
	int         ones       = 0;
	int         idle_run   = 0;
	int         frames_rx  = 0;
	int         flags_seen = 0;
	logic       last_good  = 1'b0;
	logic [7:0] last_byte  = 8'h00;

	function automatic logic [15:0] crc_step(logic [15:0] c, logic b);
		return (c[0] ^ b) ? ((c >> 1) ^ CRC_POLY_REV) : (c >> 1);
	endfunction

	task automatic push_byte(input logic [7:0] d, input bit stuff,
		inout int run);
		for (int i = 0; i < 8; i++) begin
			q_bits.push_back(d[i]);
			run = d[i] ? run + 1 : 0;
			if (stuff && run == ONES_LIMIT) begin
				q_bits.push_back(1'b0);
				run = 0;
			end
		end
	endtask

	// The closing flag of one frame opens the next one queued behind it.
	task automatic send_frame(input logic [7:0] a, input logic [7:0] c,
		input logic [7:0] d, input bit bad);
		logic [15:0] crc;
		logic [23:0] body;
		int          run;
		crc = CRC_INIT;
		body = {d, c, a};
		run = 0;
		for (int i = 0; i < 24; i++)
			crc = crc_step(crc, body[i]);
		crc = ~crc ^ {15'h0000, bad};
		push_byte(a, 1'b1, run);
		push_byte(c, 1'b1, run);
		push_byte(d, 1'b1, run);
		push_byte(crc[7:0], 1'b1, run);
		push_byte(crc[15:8], 1'b1, run);
		push_byte(FLAG_PATTERN, 1'b0, run);
	endtask

	initial rx_serial = 1'b1;

	// Flags fill the line whenever nothing else is queued.
	always @(posedge link_clock) begin
		if (q_bits.size() == 0)
			push_byte(FLAG_PATTERN, 1'b0, idle_run);
		rx_serial <= q_bits.pop_front();
	end

	always @(posedge link_clock) begin : rx_side
		logic [15:0] crc;
		int          n;
		if (tx_serial === 1'b1) begin
			ones = ones + 1;
			r_bits.push_back(1'b1);
		end else if (ones == 6) begin
			ones = 0;
			flags_seen = flags_seen + 1;
			n = r_bits.size() - 7;
			if (n >= 32 && n % 8 == 0) begin
				crc = CRC_INIT;
				for (int i = 0; i < n; i++)
					crc = crc_step(crc, r_bits[i]);
				last_good = (crc == CRC_GOOD_RESI);
				for (int i = 0; i < 8; i++)
					last_byte[i] = r_bits[n - 24 + i];
				frames_rx = frames_rx + 1;
			end
			r_bits.delete();
		end else if (ones == 5) begin
			ones = 0;
		end else begin
			ones = 0;
			r_bits.push_back(1'b0);
		end
	end
endmodule // lapb_remote_station

// file: sim/lapb_bit_oriented_link_controller_tb.sv
// Self-checking bench for the link controller and a remote station.
`timescale 1ns/1ps
module lapb_bit_oriented_link_controller_tb;
	import lapb_pkg::*;
	logic        clock;
	logic        rstn;
	logic        link_clock;
	logic        cs_n;
	logic        re_n;
	logic        we_n;
	logic [3:0]  sel;
	logic [7:0]  din;
	logic [7:0]  dout;
	logic        grant_n;
	logic        oreq_n;
	logic        ireq_n;
	logic [15:0] addr;
	logic        addr_oe;
	logic        irq_n;
	logic        txs;
	logic        rxs;
	int          n_fail    = 0;
	int          cmp_count = 0;
	int          cycles    = 0;
	int          n;
	logic [7:0]  v;
	logic [15:0] ptr;
	logic [7:0]  shadow [16];
	logic [7:0]  txb [4];

	lapb_link_ctrl u_dut (.clock(clock), .rstn(rstn),
		.link_clock(link_clock), .chip_select_n(cs_n),
		.read_strobe_n(re_n), .write_strobe_n(we_n), .reg_select(sel),
		.data_in(din), .data_out(dout), .data_oe(), .dma_grant_n(grant_n),
		.dma_out_request_n(oreq_n), .dma_in_request_n(ireq_n),
		.dma_addr_out(addr), .dma_addr_oe(addr_oe), .irq_n(irq_n),
		.tx_serial(txs), .rx_serial(rxs));
	lapb_remote_station u_remote (.link_clock(link_clock),
		.tx_serial(txs), .rx_serial(rxs));

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	initial begin
		link_clock = 1'b0;
		#1.3;
		forever #3 link_clock = ~link_clock;
	end

	task automatic final_report();
		if (n_fail == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			n_fail = n_fail + 1;
			final_report();
		end
	end

	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp1(input logic got, input logic exp);
		cmp8({7'h00, got}, {7'h00, exp});
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d,
		input logic cs);
		@(posedge clock);
		cs_n <= cs;
		we_n <= 1'b0;
		sel  <= a;
		din  <= d;
		@(posedge clock);
		cs_n <= 1'b1;
		we_n <= 1'b1;
	endtask
	// Sampled one edge after the strobe, before a clear-on-read lands.
	task automatic chk(input logic [3:0] a, input logic [7:0] e);
		@(posedge clock);
		cs_n <= 1'b0;
		re_n <= 1'b0;
		sel  <= a;
		@(posedge clock);
		#1;
		v = dout;
		@(posedge clock);
		cs_n <= 1'b1;
		re_n <= 1'b1;
		cmp8(v, e);
	endtask
	// Grant is held low until the edge after the request was seen low.
	task automatic dma_out(input logic [7:0] d);
		int i;
		i = 0;
		@(posedge clock);
		grant_n <= 1'b0;
		din     <= d;
		@(negedge clock);
		while (oreq_n !== 1'b0 && i < 400) begin
			@(negedge clock);
			i++;
		end
		cmp1(oreq_n, 1'b0);
		@(posedge clock);
		grant_n <= 1'b1;
	endtask
	task automatic dma_drain(input logic [7:0] e);
		int i;
		i = 0;
		@(posedge clock);
		grant_n <= 1'b0;
		@(negedge clock);
		while (ireq_n === 1'b0 && i < 20) begin
			@(negedge clock);
			i++;
		end
		cmp8(dout, e);
		@(posedge clock);
		grant_n <= 1'b1;
	endtask

	initial begin
		void'($urandom(32'h3c95_7874));
		{cs_n, re_n, we_n, grant_n} = 4'hf;
		sel = 4'h0;
		din = 8'h00;
		rstn = 1'b0;
		repeat (20) @(posedge clock);
		rstn <= 1'b1;
		for (int a = 0; a < 16; a++)
			shadow[a] = (a == 0) ? CR0_RESET : REG_RESET;
		shadow[4][LS_RX_IDLE_BIT] = 1'b1;
		for (int a = 0; a < 16; a++)
			chk(a[3:0], shadow[a]);
		for (int a = 2; a < 16; a++) begin
			v = 8'($urandom());
			if (a > 7 && a != 13)
				shadow[a] = v;
			wr(a[3:0], v, 1'b0);
		end
		wr(REG_RETRY_TIMER, ~shadow[8], 1'b1);
		for (int a = 2; a < 16; a++)
			chk(a[3:0], shadow[a]);
		wr(REG_CONTROL_ONE, 8'(1 << CR1_ADDR_DRIVE_BIT), 1'b0);
		grant_n <= 1'b0;
		@(negedge clock);
		cmp1(addr_oe, 1'b1);
		grant_n <= 1'b1;
		@(negedge clock);
		cmp1(addr_oe, 1'b1);
		wr(REG_CONTROL_ONE, 8'h00, 1'b0);
		@(negedge clock);
		cmp1(addr_oe, 1'b0);
		n = u_remote.flags_seen;
		repeat (100) @(posedge link_clock);
		cmp1(u_remote.flags_seen >= n + 10, 1'b1);
		wr(REG_CONTROL_ZERO, 8'(1 << CR0_RX_READY_BIT), 1'b0);
		u_remote.send_frame(8'h03, 8'h00, 8'($urandom()), 1'b1);
		repeat (400) @(posedge clock);
		cmp1(irq_n, 1'b0);
		chk(REG_ERROR_STATUS, 8'(1 << ER_CRC_BIT));
		chk(REG_LINK_STATUS, 8'(1 << LS_RX_IDLE_BIT));
		chk(REG_EVENT_STATUS, 8'(1 << EV_ERROR_BIT));
		@(negedge clock);
		cmp1(irq_n, 1'b1);
		u_remote.send_frame(8'h03, 8'h01, 8'($urandom()), 1'b0);
		u_remote.send_frame(8'h01, 8'h10, 8'hff, 1'b0);
		repeat (600) @(posedge clock);
		chk(REG_RX_CTRL_FIELD, 8'h10);
		chk(REG_ERROR_STATUS, 8'(1 << ER_CRC_BIT));
		chk(REG_EVENT_STATUS, 8'(1 << EV_PKT_RX_BIT));
		cmp1(ireq_n, 1'b0);
		dma_drain(8'hff);
		ptr = {shadow[10], shadow[11]} + 16'h0001;
		cmp8(addr[15:8], ptr[15:8]);
		cmp8(addr[7:0], ptr[7:0]);
		chk(REG_LINK_STATUS, 8'(1 << LS_RX_IDLE_BIT));
		cmp1(ireq_n, 1'b1);
		txb = '{8'h03, 8'h10, 8'hff, 8'($urandom())};
		n = u_remote.frames_rx;
		wr(REG_CONTROL_ONE, 8'(1 << CR1_SEND_BIT), 1'b0);
		foreach (txb[i])
			dma_out(txb[i]);
		wr(REG_CONTROL_ONE, 8'h00, 1'b0);
		for (int i = 0; i < 2000 && u_remote.frames_rx == n; i++)
			@(posedge clock);
		cmp1(u_remote.last_good, 1'b1);
		cmp8(u_remote.last_byte, txb[3]);
		final_report();
	end
endmodule // lapb_bit_oriented_link_controller_tb
